// >>> rtl/sct4_cfg.svh
// register addresses, field positions, reset values and timing counts of timer four
`ifndef SCT4_CFG_SVH
`define SCT4_CFG_SVH
// register pages
`define SCT4_PAGE_RUN 2'h1
`define SCT4_PAGE_MAIN 2'h2
`define SCT4_PAGE_STOP 2'h3
// register addresses
`define SCT4_ADDR_MODE_EXT 8'h93
`define SCT4_ADDR_STROBES 8'h95
`define SCT4_ADDR_CONTROL 8'hc8
`define SCT4_ADDR_MODE 8'hc9
`define SCT4_ADDR_CAP_LOW 8'hca
`define SCT4_ADDR_CAP_HIGH 8'hcb
`define SCT4_ADDR_COUNT_LOW 8'hcc
`define SCT4_ADDR_COUNT_HIGH 8'hcd
// control register fields
`define SCT4_CON_FULL_OVF 7
`define SCT4_CON_EXT_FLAG 6
`define SCT4_CON_LOW_OVF 5
`define SCT4_CON_LOW_IE 4
`define SCT4_CON_FALL_EN 3
`define SCT4_CON_RUN 2
`define SCT4_CON_CNT_SEL 1
`define SCT4_CON_CAP_SEL 0
// mode register fields
`define SCT4_MOD_SPLIT 7
`define SCT4_MOD_LOW_FAST 6
`define SCT4_MOD_RISE_EN 5
`define SCT4_MOD_FAST 4
`define SCT4_MOD_LOW_RUN 3
`define SCT4_MOD_AUTO_CLR 2
`define SCT4_MOD_CKO_EN 1
`define SCT4_MOD_MS0 0
// extended mode register fields
`define SCT4_EXT_LOW_CS 7
`define SCT4_EXT_CKS 4
`define SCT4_EXT_CAP_MSB 2
`define SCT4_EXT_RD_MASK 8'h97
// strobe fields, shared by run-set, reload and stop pages
`define SCT4_STB_LOW 7
`define SCT4_STB_MAIN 4
// reset values
`define SCT4_RST_BYTE 8'h00
// system clock divided by twelve
`define SCT4_DIV12 4'hb
`endif

// >>> rtl/sct4_pkg.sv
// types shared by timer four
package sct4_pkg;
  typedef enum logic [1:0] {
    SCT4_RELOAD_EXT,
    SCT4_RELOAD_SEP,
    SCT4_CAPTURE,
    SCT4_CAPTURE_ZERO
  } sct4_mode_e;
  typedef logic [7:0] sct4_byte_t;
endpackage

// >>> rtl/sct4_timer.sv
// timer four: 16-bit or split 8-bit timer with capture, reload and strobes
//
// Function
// - full overflow sets the full overflow flag; software clears it.
// - qualified trigger edge sets external event flag; requests timer interrupt.
// - in power-down with interrupt enabled, external flag is a level wake request.
// - split mode low-half overflow sets the low-half flag; software clears it.
// - low-half irq enable routes low-half flag onto timer interrupt.
// - mode 0 still reports enabled trigger edges on the external flag.
// - count only while main run set; split mode it gates only high half.
// - three select bits choose the count clock among eight sources.
// - two bits choose reload, separate reload, capture, capture with zero.
// - split enable makes two independent 8-bit halves.
// - split low half clock chosen by two bits among four sources.
// - rising edge enable lets rising trigger edges capture or reload.
// - falling edge enable lets falling trigger edges capture or reload.
// - split low half runs only while low-half run bit set.
// - auto-clear drops low run on high overflow in reload modes, on capture event in capture modes.
// - clock output pin driven only while clock-output enable set.
// - three-bit field selects the capture trigger among eight sources.
// - run-set strobes set main run bit, or low run bit in split mode; self clearing.
// - low reload strobe reloads the low half in split mode.
// - main reload strobe reloads both halves, or high half when split.
// - stop strobes clear main run bit, or low run bit in split mode; self clearing.
`include "sct4_cfg.svh"
module sct4_timer
  import sct4_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [1:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic external_trigger_input,
  input wire logic count_pin,
  input wire logic internal_interrupt_two,
  input wire logic uart_three_baud_overflow,
  input wire logic timer_zero_overflow,
  input wire logic comparator_two_event,
  input wire logic comparator_zero_event,
  input wire logic uart_zero_receive,
  input wire logic crystal_or_ext_clock_in,
  input wire logic internal_interrupt_one,
  input wire logic uart_three_receive,
  input wire logic comparator_zero_output,
  input wire logic comparator_two_output,
  input wire logic internal_slow_oscillator,
  input wire logic power_down,
  input wire logic timer_irq_enable,
  output logic timer_irq,
  output logic wake_request,
  output logic clock_output_pin,
  output logic clock_output_oe
);
  // software visible state
  sct4_byte_t control;
  sct4_byte_t mode;
  sct4_byte_t mode_ext;
  sct4_byte_t low_half_counter;
  sct4_byte_t high_half_counter;
  sct4_byte_t cap_low;
  sct4_byte_t cap_high;
  // internal state
  logic [3:0] div_cnt;
  logic count_pin_q;
  logic cap_src_q;
  logic cko_toggle;

  // register decode
  wire pg_main = sfr_page == `SCT4_PAGE_MAIN;
  wire wr_con = sfr_wr && pg_main && sfr_addr == `SCT4_ADDR_CONTROL;
  wire wr_mod = sfr_wr && pg_main && sfr_addr == `SCT4_ADDR_MODE;
  wire wr_ext = sfr_wr && sfr_page == `SCT4_PAGE_STOP && sfr_addr == `SCT4_ADDR_MODE_EXT;
  wire wr_tl = sfr_wr && pg_main && sfr_addr == `SCT4_ADDR_COUNT_LOW;
  wire wr_th = sfr_wr && pg_main && sfr_addr == `SCT4_ADDR_COUNT_HIGH;
  wire wr_cl = sfr_wr && pg_main && sfr_addr == `SCT4_ADDR_CAP_LOW;
  wire wr_ch = sfr_wr && pg_main && sfr_addr == `SCT4_ADDR_CAP_HIGH;
  wire wr_stb = sfr_wr && sfr_addr == `SCT4_ADDR_STROBES;

  // strobes act in the write cycle and are never stored, so they read zero
  wire stb_run_main = wr_stb && sfr_page == `SCT4_PAGE_RUN && sfr_wdata[`SCT4_STB_MAIN];
  wire stb_run_low = wr_stb && sfr_page == `SCT4_PAGE_RUN && sfr_wdata[`SCT4_STB_LOW];
  wire stb_rl_main = wr_stb && pg_main && sfr_wdata[`SCT4_STB_MAIN];
  wire stb_rl_low = wr_stb && pg_main && sfr_wdata[`SCT4_STB_LOW];
  wire stb_stop_main = wr_stb && sfr_page == `SCT4_PAGE_STOP && sfr_wdata[`SCT4_STB_MAIN];
  wire stb_stop_low = wr_stb && sfr_page == `SCT4_PAGE_STOP && sfr_wdata[`SCT4_STB_LOW];

  // field views
  wire split_enable = mode[`SCT4_MOD_SPLIT];
  wire main_run_bit = control[`SCT4_CON_RUN];
  wire low_half_run_bit = mode[`SCT4_MOD_LOW_RUN];
  wire low_run_auto_clear = mode[`SCT4_MOD_AUTO_CLR];
  wire clock_output_enable = mode[`SCT4_MOD_CKO_EN];
  wire low_half_irq_enable = control[`SCT4_CON_LOW_IE];
  wire falling_edge_enable = control[`SCT4_CON_FALL_EN];
  wire rising_edge_enable = mode[`SCT4_MOD_RISE_EN];
  sct4_mode_e op_mode;
  assign op_mode = sct4_mode_e'({control[`SCT4_CON_CAP_SEL], mode[`SCT4_MOD_MS0]});
  wire reload_mode = !control[`SCT4_CON_CAP_SEL];
  wire capture_mode = control[`SCT4_CON_CAP_SEL];
  wire [2:0] full_sel = {mode_ext[`SCT4_EXT_CKS], mode[`SCT4_MOD_FAST],
                         control[`SCT4_CON_CNT_SEL]};
  wire [1:0] low_sel = {mode_ext[`SCT4_EXT_LOW_CS], mode[`SCT4_MOD_LOW_FAST]};
  wire [2:0] cap_sel = mode_ext[`SCT4_EXT_CAP_MSB:0];

  // system_clock/12 tick; count pin counts on falling edges
  wire div12_tick = div_cnt == `SCT4_DIV12;
  wire pin_tick = count_pin_q && !count_pin;

  // low half clock in split mode
  logic low_src;
  always_comb begin
    case (low_sel)
      2'h0: low_src = div12_tick;
      2'h1: low_src = 1'b1;
      2'h2: low_src = uart_three_baud_overflow;
      2'h3: low_src = internal_interrupt_two;
      default: low_src = 1'b0;
    endcase
  end
  wire low_tick = split_enable && low_half_run_bit && low_src;
  wire low_half_overflow_pulse = low_tick && low_half_counter == 8'hff;

  // main clock; in split mode select 3 gives the high half the low overflow instead of interrupt two
  logic full_src;
  always_comb begin
    case (full_sel)
      3'h0: full_src = div12_tick;
      3'h1: full_src = pin_tick;
      3'h2: full_src = 1'b1;
      3'h3: full_src = split_enable ? low_half_overflow_pulse : internal_interrupt_two;
      3'h4: full_src = uart_three_baud_overflow;
      3'h5: full_src = timer_zero_overflow;
      3'h6: full_src = comparator_two_event;
      3'h7: full_src = comparator_zero_event;
      default: full_src = 1'b0;
    endcase
  end
  wire main_tick = main_run_bit && full_src;
  wire full_tick = !split_enable && main_tick;
  wire high_tick = split_enable && main_tick;
  wire full_ovf = full_tick && {high_half_counter, low_half_counter} == 16'hffff;
  wire high_ovf = high_tick && high_half_counter == 8'hff;
  wire top_ovf = split_enable ? high_ovf : full_ovf;

  // capture trigger selection and edge qualification
  logic cap_src;
  always_comb begin
    case (cap_sel)
      3'h0: cap_src = external_trigger_input;
      3'h1: cap_src = uart_zero_receive;
      3'h2: cap_src = crystal_or_ext_clock_in;
      3'h3: cap_src = internal_interrupt_one;
      3'h4: cap_src = uart_three_receive;
      3'h5: cap_src = comparator_zero_output;
      3'h6: cap_src = comparator_two_output;
      3'h7: cap_src = internal_slow_oscillator;
      default: cap_src = 1'b0;
    endcase
  end
  wire rise_ev = rising_edge_enable && cap_src && !cap_src_q;
  wire fall_ev = falling_edge_enable && !cap_src && cap_src_q;
  wire ext_ev = rise_ev || fall_ev;
  wire cap_ev = ext_ev && capture_mode;
  wire ext_reload = ext_ev && op_mode == SCT4_RELOAD_SEP;
  wire zero_ev = cap_ev && op_mode == SCT4_CAPTURE_ZERO;

  // reload requests per half
  wire reload_low = split_enable ? (reload_mode && low_half_overflow_pulse) || stb_rl_low
                                 : (reload_mode && full_ovf) || stb_rl_main;
  wire reload_high = (reload_mode && top_ovf) || stb_rl_main;

  // next counter values: software write, auto-zero, reload, count
  sct4_byte_t next_tl;
  sct4_byte_t next_th;
  always_comb begin
    next_tl = low_half_counter;
    if (wr_tl) begin
      next_tl = sfr_wdata;
    end else if (zero_ev) begin
      next_tl = 8'h00;
    end else if (reload_low || ext_reload) begin
      next_tl = cap_low;
    end else if (low_tick || full_tick) begin
      next_tl = low_half_counter + 8'h01;
    end
  end
  wire carry_high = full_tick && low_half_counter == 8'hff;
  always_comb begin
    next_th = high_half_counter;
    if (wr_th) begin
      next_th = sfr_wdata;
    end else if (zero_ev) begin
      next_th = 8'h00;
    end else if (reload_high || ext_reload) begin
      next_th = cap_high;
    end else if (high_tick || carry_high) begin
      next_th = high_half_counter + 8'h01;
    end
  end

  // run bits: stop and hardware clear win over set
  wire run_clr_hw = low_run_auto_clear && (reload_mode ? top_ovf : cap_ev);
  wire next_main_run = (wr_con ? sfr_wdata[`SCT4_CON_RUN] : main_run_bit | stb_run_main)
                       && !stb_stop_main;
  wire next_low_run = (wr_mod ? sfr_wdata[`SCT4_MOD_LOW_RUN] : low_half_run_bit
                       | (stb_run_low && split_enable))
                      && !(stb_stop_low && split_enable) && !run_clr_hw;

  // flags: a hardware set wins over a software clear in the same cycle
  wire next_full_flag = (wr_con ? sfr_wdata[`SCT4_CON_FULL_OVF]
                         : control[`SCT4_CON_FULL_OVF]) || top_ovf;
  wire next_ext_flag = (wr_con ? sfr_wdata[`SCT4_CON_EXT_FLAG]
                        : control[`SCT4_CON_EXT_FLAG]) || ext_ev;
  wire next_low_flag = (wr_con ? sfr_wdata[`SCT4_CON_LOW_OVF]
                        : control[`SCT4_CON_LOW_OVF]) || low_half_overflow_pulse;
  wire [7:0] next_control = {next_full_flag, next_ext_flag, next_low_flag,
                             wr_con ? sfr_wdata[4:3] : control[4:3], next_main_run,
                             wr_con ? sfr_wdata[1:0] : control[1:0]};
  wire [7:0] next_mode = {wr_mod ? sfr_wdata[7:4] : mode[7:4], next_low_run,
                          wr_mod ? sfr_wdata[2:0] : mode[2:0]};

  // interrupt and wake; flags stay asserted as levels
  wire next_irq = next_full_flag || next_ext_flag
                  || (next_low_flag && low_half_irq_enable);
  wire next_wake = power_down && timer_irq_enable && next_ext_flag;

  // read mux, unmapped addresses and strobes read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (pg_main) begin
      case (sfr_addr)
        `SCT4_ADDR_CONTROL: rd_mux = control;
        `SCT4_ADDR_MODE: rd_mux = mode;
        `SCT4_ADDR_COUNT_LOW: rd_mux = low_half_counter;
        `SCT4_ADDR_COUNT_HIGH: rd_mux = high_half_counter;
        `SCT4_ADDR_CAP_LOW: rd_mux = cap_low;
        `SCT4_ADDR_CAP_HIGH: rd_mux = cap_high;
        default: rd_mux = 8'h00;
      endcase
    end else if (sfr_page == `SCT4_PAGE_STOP && sfr_addr == `SCT4_ADDR_MODE_EXT) begin
      rd_mux = mode_ext & `SCT4_EXT_RD_MASK;
    end
  end

  // prescaler and edge samplers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      div_cnt <= 4'h0;
      count_pin_q <= 1'b0;
      cap_src_q <= 1'b0;
    end else if (clk_en) begin
      div_cnt <= div12_tick ? 4'h0 : div_cnt + 4'h1;
      count_pin_q <= count_pin;
      cap_src_q <= cap_src;
    end
  end

  // control, mode and counters
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      control <= `SCT4_RST_BYTE;
      mode <= `SCT4_RST_BYTE;
      mode_ext <= `SCT4_RST_BYTE;
      low_half_counter <= `SCT4_RST_BYTE;
      high_half_counter <= `SCT4_RST_BYTE;
    end else if (clk_en) begin
      control <= next_control;
      mode <= next_mode;
      if (wr_ext) begin
        mode_ext <= sfr_wdata & `SCT4_EXT_RD_MASK; // reserved bits never stored
      end
      low_half_counter <= next_tl;
      high_half_counter <= next_th;
    end
  end

  // capture pair; a capture event wins over a software write
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cap_low <= `SCT4_RST_BYTE;
      cap_high <= `SCT4_RST_BYTE;
    end else if (clk_en) begin
      if (cap_ev) begin
        cap_low <= low_half_counter;
        cap_high <= high_half_counter;
      end else begin
        if (wr_cl) cap_low <= sfr_wdata;
        if (wr_ch) cap_high <= sfr_wdata;
      end
    end
  end

  // registered outputs; clock out toggles on each top overflow
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
      timer_irq <= 1'b0;
      wake_request <= 1'b0;
      cko_toggle <= 1'b0;
      clock_output_pin <= 1'b0;
      clock_output_oe <= 1'b0;
    end else if (clk_en) begin
      if (sfr_rd) sfr_rdata <= rd_mux;
      timer_irq <= next_irq;
      wake_request <= next_wake;
      cko_toggle <= cko_toggle ^ top_ovf;
      clock_output_pin <= clock_output_enable && (cko_toggle ^ top_ovf);
      clock_output_oe <= clock_output_enable;
    end
  end

  // checks
  full_flag_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && top_ovf |=> control[`SCT4_CON_FULL_OVF])
    else $error("full overflow flag not set");
  ext_flag_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && ext_ev |=> control[`SCT4_CON_EXT_FLAG] ##1 timer_irq || !clk_en)
    else $error("external flag or interrupt missing");
  low_flag_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && low_half_overflow_pulse |=> control[`SCT4_CON_LOW_OVF])
    else $error("low half flag not set");
  low_irq_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && $past(clk_en) && !$past(next_full_flag) && !$past(next_ext_flag)
    |-> timer_irq == $past(next_low_flag && low_half_irq_enable))
    else $error("low half interrupt gating wrong");
  run_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && stb_run_main && !stb_stop_main && !wr_con |=> main_run_bit)
    else $error("run strobe did not set run bit");
  run_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && stb_stop_main |=> !main_run_bit)
    else $error("stop strobe did not clear run bit");
  auto_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && run_clr_hw |=> !low_half_run_bit)
    else $error("low run not auto cleared");
  cko_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !clock_output_oe |-> !clock_output_pin)
    else $error("clock out driven while disabled");
  capture_copy_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && cap_ev |=> {cap_high, cap_low} == $past({high_half_counter, low_half_counter}))
    else $error("capture pair not loaded");
  stopped_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !split_enable && !main_run_bit && !wr_tl && !wr_th && !ext_ev && !stb_rl_main
    |=> high_half_counter == $past(high_half_counter))
    else $error("counter moved while stopped");
  low_reload_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && split_enable && stb_rl_low && !wr_tl && !zero_ev
    |=> low_half_counter == $past(cap_low))
    else $error("low half not reloaded");
  main_reload_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && stb_rl_main && !wr_th && !zero_ev
    |=> high_half_counter == $past(cap_high))
    else $error("high half not reloaded");
  low_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && split_enable && !low_half_run_bit && !wr_tl && !zero_ev && !ext_reload
    && !stb_rl_low |=> low_half_counter == $past(low_half_counter))
    else $error("low half moved while stopped");
  auto_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && zero_ev && !wr_tl && !wr_th
    |=> {high_half_counter, low_half_counter} == 16'h0000)
    else $error("counter not zeroed at capture");
  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !clk_en |=> control == $past(control) && mode == $past(mode)
    && {high_half_counter, low_half_counter} == $past({high_half_counter, low_half_counter}))
    else $error("state moved while clock enable low");
  wake_level_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !wr_con && power_down && timer_irq_enable && control[`SCT4_CON_EXT_FLAG]
    |=> wake_request)
    else $error("wake request missing");
endmodule // sct4_timer

// >>> verification/sct4_src_model.sv
// neighbour model: trigger pin, count pin, tick pulses and capture levels
module sct4_src_model (
  input wire logic ref_clk,
  output logic trig,
  output logic count_pin,
  output logic [4:0] ticks,
  output logic [6:0] levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // all lines idle low, as the real sources rest between events
  initial begin
    trig = 1'b0;
    count_pin = 1'b0;
    ticks = 5'h00;
    levels = 7'h00;
  end
  // changes land at the falling edge, clear of the sampling edge
  task automatic set_trig(input logic v);
    @(negedge ref_clk);
    trig = v;
  endtask
  task automatic set_level(input int idx, input logic v);
    @(negedge ref_clk);
    levels = {6'h00, v} << idx; // only one source is ever raised at a time
  endtask
  // code 1 is the count pin (falling edge counts), codes 3..7 one-cycle ticks
  task automatic pulse(input int code, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      if (code == 1) begin
        count_pin = 1'b1;
      end else begin
        ticks = 5'h01 << (code - 3);
      end
      @(negedge ref_clk);
      count_pin = 1'b0;
      ticks = 5'h00;
      @(negedge ref_clk);
    end
  endtask
endmodule // sct4_src_model

// >>> verification/tb_split_capable_timer_four.sv
// self-checking bench for timer four through its register bus
module tb_split_capable_timer_four;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] pr = 2'h1;
  localparam logic [1:0] pm = 2'h2;
  localparam logic [1:0] ps = 2'h3;
  logic ref_clk = 1'b0;
  logic clk_en = 1'b1;
  logic resetn, sfr_wr, sfr_rd, power_down, timer_irq_enable;
  logic [1:0] sfr_page;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic timer_irq, wake_request, clock_output_pin, clock_output_oe, trig, count_pin;
  logic [4:0] ticks;
  logic [6:0] levels;
  logic [2:0] c;
  int n_mismatch = 0;
  int cmp_count = 0;
  // 20 MHz
  always #25 ref_clk = ~ref_clk;
  sct4_src_model sct4_src_model_i (.ref_clk(ref_clk), .trig(trig), .count_pin(count_pin),
    .ticks(ticks), .levels(levels));
  sct4_timer sct4_timer_i (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .external_trigger_input(trig),
    .count_pin(count_pin), .internal_interrupt_two(ticks[0]),
    .uart_three_baud_overflow(ticks[1]), .timer_zero_overflow(ticks[2]),
    .comparator_two_event(ticks[3]), .comparator_zero_event(ticks[4]),
    .uart_zero_receive(levels[0]), .crystal_or_ext_clock_in(levels[1]),
    .internal_interrupt_one(levels[2]), .uart_three_receive(levels[3]),
    .comparator_zero_output(levels[4]), .comparator_two_output(levels[5]),
    .internal_slow_oscillator(levels[6]), .power_down(power_down),
    .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq),
    .wake_request(wake_request), .clock_output_pin(clock_output_pin),
    .clock_output_oe(clock_output_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle write pulse, held from falling edge to falling edge
  task automatic wr(input logic [1:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_page = pg;
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  // read data is registered, so it is settled one edge after the strobe
  task automatic rd(input logic [1:0] pg, input logic [7:0] ad, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_page = pg;
    sfr_addr = ad;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  task automatic set_cnt(input logic [15:0] v);
    wr(pm, 8'hcc, v[7:0]);
    wr(pm, 8'hcd, v[15:8]);
  endtask
  task automatic set_cap(input logic [15:0] v);
    wr(pm, 8'hca, v[7:0]);
    wr(pm, 8'hcb, v[15:8]);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic edge_pair();
    sct4_src_model_i.set_trig(1'b1);
    sct4_src_model_i.set_trig(1'b0);
    wait_cyc(3);
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    {sfr_wr, sfr_rd, power_down, timer_irq_enable} = 4'h0;
    sfr_page = 2'h0;
    {sfr_addr, sfr_wdata} = 16'h0000;
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    for (int a = 8'hc8; a <= 8'hcd; a++) rd(pm, 8'(a), 8'h00);
    rd(ps, 8'h93, 8'h00);
    rd(pr, 8'h95, 8'h00);
    rd(2'h0, 8'hc8, 8'h00);
    rd(pm, 8'ha0, 8'h00);
    // every writable extended bit, reserved ones always written as zero
    wr(ps, 8'h93, 8'h97);
    rd(ps, 8'h93, 8'h97);
    wr(ps, 8'h93, 8'h00);
    set_cnt(16'h5555);
    set_cap(16'ha1b2);
    wr(pm, 8'h95, 8'h00);
    rd(pm, 8'hcc, 8'h55);
    wr(pm, 8'h95, 8'h10);
    rd(pm, 8'hcc, 8'hb2);
    rd(pm, 8'hcd, 8'ha1);
    // full overflow with reload and clock out, run and stop by strobes
    set_cap(16'h1234);
    set_cnt(16'hfff0);
    wr(pm, 8'hc9, 8'h12);
    wr(pr, 8'h95, 8'h10);
    rd(pm, 8'hc8, 8'h04);
    wait_cyc(30);
    wr(ps, 8'h95, 8'h10);
    rd(pm, 8'hc8, 8'h80);
    rd(pm, 8'hcd, 8'h12);
    chk({7'h00, timer_irq}, 8'h01);
    chk({6'h00, clock_output_oe, clock_output_pin}, 8'h03);
    wr(pm, 8'hc9, 8'h10);
    wait_cyc(2);
    chk({6'h00, clock_output_oe, clock_output_pin}, 8'h00);
    wr(pm, 8'hc8, 8'h00);
    wait_cyc(3);
    chk({7'h00, timer_irq}, 8'h00);
    // count clock sources other than the system clock and system clock/12
    for (int k = 1; k < 8; k++) begin
      if (k != 2) begin
        c = 3'(k);
        wr(ps, 8'h93, {3'h0, c[2], 4'h0});
        wr(pm, 8'hc9, {3'h0, c[1], 4'h0});
        set_cnt(16'h0000);
        wr(pm, 8'hc8, {6'h01, c[0], 1'b0});
        sct4_src_model_i.pulse(k, 3);
        wr(pm, 8'hc8, {6'h00, c[0], 1'b0});
        rd(pm, 8'hcc, 8'h03);
      end
    end
    // capture on falling edge only, then rising with auto-zero
    wr(ps, 8'h93, 8'h00);
    wr(pm, 8'hc9, 8'h00);
    set_cnt(16'h4321);
    wr(pm, 8'hc8, 8'h09);
    sct4_src_model_i.set_trig(1'b1);
    wait_cyc(3);
    rd(pm, 8'hc8, 8'h09);
    sct4_src_model_i.set_trig(1'b0);
    wait_cyc(3);
    rd(pm, 8'hc8, 8'h49);
    rd(pm, 8'hca, 8'h21);
    rd(pm, 8'hcb, 8'h43);
    wr(pm, 8'hc8, 8'h01);
    wr(pm, 8'hc9, 8'h21);
    set_cnt(16'h0abc);
    sct4_src_model_i.set_trig(1'b1);
    wait_cyc(3);
    rd(pm, 8'hc8, 8'h41);
    rd(pm, 8'hcb, 8'h0a);
    rd(pm, 8'hcc, 8'h00);
    power_down = 1'b1;
    timer_irq_enable = 1'b1;
    wait_cyc(3);
    chk({6'h00, wake_request, timer_irq}, 8'h03);
    timer_irq_enable = 1'b0;
    wait_cyc(3);
    chk({7'h00, wake_request}, 8'h00);
    power_down = 1'b0;
    wr(pm, 8'hc8, 8'h01);
    sct4_src_model_i.set_trig(1'b0);
    wait_cyc(3);
    rd(pm, 8'hc8, 8'h01);
    // mode 0 flags only; mode 1 reloads on the trigger
    wr(pm, 8'hc9, 8'h00);
    set_cnt(16'h1111);
    wr(pm, 8'hc8, 8'h08);
    edge_pair();
    rd(pm, 8'hc8, 8'h48);
    rd(pm, 8'hcc, 8'h11);
    wr(pm, 8'hc9, 8'h01);
    wr(pm, 8'hc8, 8'h08);
    edge_pair();
    rd(pm, 8'hcd, 8'h0a);
    // every other capture source raises the external flag
    wr(pm, 8'hc9, 8'h00);
    wr(pm, 8'hc8, 8'h09);
    for (int k = 1; k < 8; k++) begin
      wr(ps, 8'h93, 8'(k));
      sct4_src_model_i.set_level(k - 1, 1'b1);
      sct4_src_model_i.set_level(k - 1, 1'b0);
      wait_cyc(3);
      rd(pm, 8'hc8, 8'h49);
      wr(pm, 8'hc8, 8'h09);
    end
    wr(ps, 8'h93, 8'h00);
    wr(pm, 8'hc8, 8'h00);
    // split: low half overflow, low run strobes, high half held by main run
    set_cap(16'h0000);
    set_cnt(16'h00f8);
    wr(pm, 8'hc9, 8'hc0);
    wr(pr, 8'h95, 8'h80);
    rd(pm, 8'hc9, 8'hc8);
    wait_cyc(20);
    wr(ps, 8'h95, 8'h80);
    rd(pm, 8'hc9, 8'hc0);
    rd(pm, 8'hc8, 8'h20);
    rd(pm, 8'hcd, 8'h00);
    chk({7'h00, timer_irq}, 8'h00);
    wr(pm, 8'hc8, 8'h30);
    wait_cyc(3);
    chk({7'h00, timer_irq}, 8'h01);
    wr(pm, 8'hc8, 8'h00);
    // low half ticks from the baud overflow and interrupt-two sources
    for (int lc = 2; lc < 4; lc++) begin
      c = 3'(lc);
      wr(ps, 8'h93, {c[1], 7'h00});
      wr(pm, 8'hc9, {1'b1, c[0], 6'h08});
      set_cnt(16'h0000);
      sct4_src_model_i.pulse(6 - lc, 3);
      wr(pm, 8'hc9, 8'h80);
      rd(pm, 8'hcc, 8'h03);
    end
    wr(ps, 8'h93, 8'h00);
    set_cap(16'h0077);
    wr(pm, 8'h95, 8'h80);
    rd(pm, 8'hcc, 8'h77);
    set_cap(16'h6655);
    wr(pm, 8'h95, 8'h10);
    rd(pm, 8'hcd, 8'h66);
    rd(pm, 8'hcc, 8'h77);
    // high half overflow drops the low run bit when auto-clear is set
    set_cnt(16'hfe00);
    wr(pm, 8'hc9, 8'hdc);
    wr(pm, 8'hc8, 8'h04);
    wait_cyc(6);
    wr(pm, 8'hc8, 8'h00);
    rd(pm, 8'hc9, 8'hd4);
    // clock enable low: strobes and writes are lost while frozen
    wr(pm, 8'hc9, 8'h10);
    set_cnt(16'h0000);
    @(negedge ref_clk);
    clk_en = 1'b0;
    wr(pr, 8'h95, 8'h10);
    wr(pm, 8'hcc, 8'h5a);
    @(negedge ref_clk);
    clk_en = 1'b1;
    rd(pm, 8'hc8, 8'h00);
    rd(pm, 8'hcc, 8'h00);
    wrap_up();
  end
endmodule // tb_split_capable_timer_four
